// [hw/dss_status.sv]
// Primary-side second status register with sticky fault requests
// Functional notes
// [R1] Tristate-control bit mirrors the secondary control bit set by output-stage monitor events.
// [R2] Shoot-through inhibit bit is 1 while the inhibition time runs, else 0.
// [R3] Overtemperature bit mirrors the secondary overtemperature status.
// [R4] Output-tristated bit is 1 while the output stage is tristated.
// [R5] Mode field shows the active mode 0..6, code 7 reserved, mirrored from the secondary side.
// [R6] Sticky bit shows fault pin B driven low.
// [R7] Sticky bit shows fault pin A driven low.
// [R8] Enable-valid bit is 1 when the enable pin signal is valid, else 0.
// [R9] Last-message-invalid bit is 1 if the previous SPI message was discarded.
// [R10] Bit 0 makes the whole returned word odd parity.
// [R11] The sticky enable-error flag cannot be cleared while enable-valid reads 0.
// [R12] Fields come from hardware only, upper bits read 0, writes are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "dss_defs.svh"
module dss_status
    import dss_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       tristate_control_mirror_in,
    input  wire logic       shoot_through_inhibit_in,
    input  wire logic       overtemp_status_in,
    input  wire logic       output_tristated_in,
    input  wire dss_mode_t  op_mode_in,
    input  wire logic       fault_b_set_in,
    input  wire logic       fault_a_set_in,
    input  wire logic       fault_clear_in,
    input  wire logic       enable_input_valid_in,
    input  wire logic       msg_done_in,
    input  wire logic       msg_discarded_in,
    input  wire logic       enable_error_set_in,
    input  wire logic       enable_error_clear_in,
    input  wire logic       rd_en_in,
    input  wire logic [1:0] rd_addr_in,
    input  wire logic       wr_en_in,
    input  wire dss_word_t  wr_data_in,
    output dss_word_t       rd_data_out,
    output logic            rd_valid_out,
    output logic            fault_pin_a_oe_out,
    output logic            fault_pin_b_oe_out,
    output logic            enable_error_flag_out
);
    ////////////////////////////////////////////////////////////////////////
    // Pin-side inputs cross in through two flops; stage one is read by
    // stage two only
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] pins;
    assign pins = {tristate_control_mirror_in, shoot_through_inhibit_in,
                   overtemp_status_in, output_tristated_in, op_mode_in,
                   enable_input_valid_in};
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the same cycle as a clear wins, so an event
    // that meets a host clear is never lost
    logic fault_a_r;
    logic fault_a_nxt;
    logic fault_b_r;
    logic fault_b_nxt;
    logic last_bad_r;
    logic last_bad_nxt;
    logic en_err_r;
    logic en_err_nxt;
    always_comb begin
        fault_a_nxt = fault_a_r;
        if (fault_clear_in) begin
            fault_a_nxt = 1'b0;
        end
        if (fault_a_set_in) begin
            fault_a_nxt = 1'b1; // [R7]
        end
        fault_b_nxt = fault_b_r;
        if (fault_clear_in) begin
            fault_b_nxt = 1'b0;
        end
        if (fault_b_set_in) begin
            fault_b_nxt = 1'b1; // [R6]
        end
        last_bad_nxt = last_bad_r;
        if (msg_done_in) begin
            last_bad_nxt = msg_discarded_in; // [R9]
        end
        en_err_nxt = en_err_r;
        // Clear blocked while enable is judged invalid
        if (enable_error_clear_in && sync2_r[0]) begin
            en_err_nxt = 1'b0; // [R11]
        end
        if (enable_error_set_in) begin
            en_err_nxt = 1'b1;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            fault_a_r  <= 1'b0;
            fault_b_r  <= 1'b1;
            last_bad_r <= 1'b0;
            en_err_r   <= 1'b0;
        end else begin
            fault_a_r  <= fault_a_nxt;
            fault_b_r  <= fault_b_nxt;
            last_bad_r <= last_bad_nxt;
            en_err_r   <= en_err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; write strobe and data have no effect on any field
    dss_word_t word;
    dss_word_t rd_data_nxt;
    logic      rd_valid_nxt;
    always_comb begin
        word = 16'h0000; // [R12]
        word[`DSS_BIT_TRI_CTRL]  = sync2_r[7]; // [R1]
        word[`DSS_BIT_SHOOT_INH] = sync2_r[6]; // [R2]
        word[`DSS_BIT_OVERTEMP]  = sync2_r[5]; // [R3]
        word[`DSS_BIT_TRISTATED] = sync2_r[4]; // [R4]
        word[`DSS_MODE_HI:`DSS_MODE_LO] = sync2_r[3:1]; // [R5]
        word[`DSS_BIT_FAULT_B]  = fault_b_r;
        word[`DSS_BIT_FAULT_A]  = fault_a_r;
        word[`DSS_BIT_EN_VALID] = sync2_r[0]; // [R8]
        word[`DSS_BIT_LAST_BAD] = last_bad_r;
        word[`DSS_BIT_PARITY]   = ~(^word[15:1]); // [R10]
        rd_valid_nxt = rd_en_in && (rd_addr_in == `DSS_OFS_SECOND_STATUS);
        rd_data_nxt  = rd_valid_nxt ? word : 16'h0000;
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rd_data_out           <= 16'h0000;
            rd_valid_out          <= 1'b0;
            fault_pin_a_oe_out    <= 1'b0;
            fault_pin_b_oe_out    <= 1'b0;
            enable_error_flag_out <= 1'b0;
        end else begin
            rd_data_out           <= rd_data_nxt;
            rd_valid_out          <= rd_valid_nxt;
            fault_pin_a_oe_out    <= fault_a_r; // [R7]
            fault_pin_b_oe_out    <= fault_b_r; // [R6]
            enable_error_flag_out <= en_err_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_parity_odd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_out |-> ^rd_data_out) else $error("even parity"); // [R10]
    a_upper_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_data_out[15:12] == 4'h0) else $error("upper bits set"); // [R12]
    a_en_err_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (en_err_r && !sync2_r[0]) |=> en_err_r) // [R11]
        else $error("enable error cleared");
    a_fault_a_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        fault_a_set_in |=> fault_a_r ##1 fault_pin_a_oe_out)
        else $error("fault a lost"); // [R7]
    a_fault_b_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        fault_b_set_in |=> fault_b_r ##1 fault_pin_b_oe_out)
        else $error("fault b lost"); // [R6]
    a_last_track: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        msg_done_in |=> last_bad_r == $past(msg_discarded_in)) // [R9]
        else $error("last message flag wrong");
    a_valid_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[2] == $past(sync2_r[0])) // [R8]
        else $error("enable valid wrong");
    a_shoot_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[10] == $past(sync2_r[6])) // [R2]
        else $error("shoot inhibit wrong");
    a_mode_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[7:5] == $past(sync2_r[3:1])) // [R5]
        else $error("mode wrong");
    a_hot_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[9] == $past(sync2_r[5])) // [R3]
        else $error("overtemp wrong");

    ////////////////////////////////////////////////////////////////////////
    // Remaining fields of a read and the sticky edge cases
    a_tri_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[11] == $past(sync2_r[7])) // [R1]
        else $error("tristate control wrong");
    a_tristd_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[8] == $past(sync2_r[4])) // [R4]
        else $error("tristated wrong");
    a_fault_b_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[4] == $past(fault_b_r)) // [R6]
        else $error("fault b bit wrong");
    a_fault_a_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[3] == $past(fault_a_r)) // [R7]
        else $error("fault a bit wrong");
    a_last_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_data_out[1] == $past(last_bad_r)) // [R9]
        else $error("last message bit wrong");
    a_refused: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !rd_valid_nxt |=> rd_data_out == 16'h0000) // [R12]
        else $error("data without read");
    a_valid_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_valid_nxt |=> rd_valid_out) // [R12]
        else $error("read not answered");
    a_set_wins_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (fault_a_set_in && fault_clear_in) |=> fault_a_r) // [R7]
        else $error("fault a set lost to clear");
    a_set_wins_b: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (fault_b_set_in && fault_clear_in) |=> fault_b_r) // [R6]
        else $error("fault b set lost to clear");
    a_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (fault_clear_in && !fault_a_set_in) |=> !fault_a_r) // [R7]
        else $error("fault a not cleared");
    a_clear_b: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (fault_clear_in && !fault_b_set_in) |=> !fault_b_r) // [R6]
        else $error("fault b not cleared");
    a_en_err_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        enable_error_set_in |=> en_err_r ##1 enable_error_flag_out) // [R11]
        else $error("enable error lost");
endmodule
`default_nettype wire

// [shared/dss_defs.svh]
// Offsets, field positions, reset values for the second status register
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH
`define DSS_OFS_SECOND_STATUS 2'h2
`define DSS_RST_SECOND_STATUS 16'h0010
`define DSS_BIT_TRI_CTRL      11
`define DSS_BIT_SHOOT_INH     10
`define DSS_BIT_OVERTEMP      9
`define DSS_BIT_TRISTATED     8
`define DSS_MODE_HI           7
`define DSS_MODE_LO           5
`define DSS_BIT_FAULT_B       4
`define DSS_BIT_FAULT_A       3
`define DSS_BIT_EN_VALID      2
`define DSS_BIT_LAST_BAD      1
`define DSS_BIT_PARITY        0
`define DSS_MODE_RESERVED     3'h7
`endif

// [shared/dss_pkg.sv]
// Types for the second status register block
package dss_pkg;
    typedef logic [2:0]  dss_mode_t;
    typedef logic [15:0] dss_word_t;
endpackage

// [tb/dss_host_model.sv]
// Host-side reader model for the second status register
`timescale 1ns/10ps
`default_nettype none
module dss_host_model
    import dss_pkg::*;
(
    input  wire logic      clk_in,
    input  wire logic      valid_in,
    input  wire dss_word_t data_in,
    output logic           rd_en_out,
    output logic [1:0]     addr_out
);
    initial begin
        rd_en_out = 1'h0;
        addr_out  = 2'h0;
    end
    // Idle address is inverted so a stale value never looks like a request
    task automatic read(input logic [1:0] a, output dss_word_t d,
                        output logic v);
        v = 1'h0;
        d = 16'h0000;
        repeat (3) @(posedge clk_in);
        #1 rd_en_out = 1'h1;
        addr_out = a;
        @(posedge clk_in);
        #1 rd_en_out = 1'h0;
        addr_out = ~a;
        for (int k = 0; k < 4 && !v; k++) begin
            @(posedge clk_in);
            if (valid_in === 1'h1) begin
                v = 1'h1;
                d = data_in;
            end
        end
        if (!v) d = data_in;
        #1;
    endtask
endmodule
`default_nettype wire

// [tb/tb_dss_status.sv]
// Testbench for the second status register
`timescale 1ns/10ps
`default_nettype none
module tb_dss_status
    import dss_pkg::*;
;
    logic clk = 1'h0, rst = 1'h1, tc = 1'h0, shoot = 1'h0, hot = 1'h0;
    logic tristd = 1'h0, ev = 1'h0, fbs = 1'h0, fas = 1'h0, fclr = 1'h0;
    logic md = 1'h0, dis = 1'h0, ees = 1'h0, eec = 1'h0, wen = 1'h0;
    logic rd_en, rv, oea, oeb, eef, efa = 1'h0, efb = 1'h1, elmi = 1'h0;
    logic [1:0] ra;
    dss_mode_t mode = 3'h0;
    dss_word_t wd = 16'h0000, rd;
    int error_cnt = 0, total_checks = 0;
    always #5 clk = ~clk;
    dss_status dss_status_inst (.sys_clk_in(clk), .rst_in(rst),
        .tristate_control_mirror_in(tc), .shoot_through_inhibit_in(shoot),
        .overtemp_status_in(hot), .output_tristated_in(tristd),
        .op_mode_in(mode), .fault_b_set_in(fbs), .fault_a_set_in(fas),
        .fault_clear_in(fclr), .enable_input_valid_in(ev),
        .msg_done_in(md), .msg_discarded_in(dis),
        .enable_error_set_in(ees), .enable_error_clear_in(eec),
        .rd_en_in(rd_en), .rd_addr_in(ra), .wr_en_in(wen),
        .wr_data_in(wd), .rd_data_out(rd), .rd_valid_out(rv),
        .fault_pin_a_oe_out(oea), .fault_pin_b_oe_out(oeb),
        .enable_error_flag_out(eef));
    dss_host_model dss_host_model_inst (.clk_in(clk), .valid_in(rv),
        .data_in(rd), .rd_en_out(rd_en), .addr_out(ra));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic ck(input string n, input dss_word_t e, input dss_word_t g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // Expected word: upper bits zero, bit 0 makes the word odd parity
    function automatic dss_word_t ew();
        logic [10:0] s;
        s = {tc, shoot, hot, tristd, mode, efb, efa, ev, elmi};
        return {4'h0, s, ~^s};
    endfunction
    task automatic rdck(input logic [1:0] a);
        dss_word_t d;
        logic v;
        dss_host_model_inst.read(a, d, v);
        ck("rd_valid", {15'h0, a == 2'h2}, {15'h0, v});
        ck("rd_data", (a == 2'h2) ? ew() : 16'h0000, d);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1'h1;
        @(posedge clk);
        #1 s = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'h0;
        rdck(2'h2);
        ck("oe_b", 16'h0001, {15'h0, oeb});
        wd = 16'hFFFF;
        pulse(wen);
        rdck(2'h2);
        pulse(fclr);
        efb = 1'h0;
        rdck(2'h2);
        pulse(fas);
        efa = 1'h1;
        rdck(2'h2);
        ck("oe_ab", 16'h0002, {14'h0, oea, oeb});
        pulse(fbs);
        efb = 1'h1;
        rdck(2'h2);
        @(posedge clk);
        #1 fas = 1'h1;
        fclr = 1'h1;
        @(posedge clk);
        #1 fas = 1'h0;
        fclr = 1'h0;
        efb = 1'h0;
        rdck(2'h2);
        for (int i = 0; i < 8; i++) begin
            {hot, shoot, tc} = 3'(i);
            tristd = ~tc;
            ev = shoot ^ hot;
            mode = 3'(i);
            rdck(2'h2);
        end
        dis = 1'h1;
        pulse(md);
        elmi = 1'h1;
        rdck(2'h2);
        dis = 1'h0;
        pulse(md);
        elmi = 1'h0;
        rdck(2'h2);
        pulse(ees);
        pulse(eec);
        repeat (2) @(posedge clk);
        ck("en_err", 16'h0001, {15'h0, eef});
        ev = 1'h1;
        repeat (3) @(posedge clk);
        pulse(eec);
        repeat (2) @(posedge clk);
        ck("en_err", 16'h0000, {15'h0, eef});
        rdck(2'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
